// ### core/fir_ident_reset.sv
`include "fir_regs.svh"

module fir_ident_reset
   import fir_pkg::*;
#(
   parameter logic [7:0]   MAKER_ID  = 8'h5a,     // arbitrary value
   parameter logic [7:0]   DEVICE_ID = 8'h3c,     // arbitrary value
   parameter logic [15:0]  TYPE_CAP  = 16'h1234,  // arbitrary value
   parameter logic [127:0] UNIQUE_NO = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210, // arbitrary value
   parameter logic [127:0] PARAM_TBL = 128'h0
) (
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire logic       sclk,
   input  wire logic       csN,
   input  wire logic       si,
   output logic            so,
   output logic            soOeN,
   input  wire logic       quadCommandMode,
   input  wire logic       quadEnableBit,
   input  wire logic       holdResetN,
   input  wire logic       dedResetN,
   input  wire logic       dedResetDisable,
   input  wire logic       writeInProgressFlag,
   input  wire logic       deepPdEnter,
   input  wire logic       protErrSet,
   input  wire logic       progErrSet,
   input  wire logic       eraseErrSet,
   input  wire logic [7:0] nvReadParams,
   output logic            protectionErrorFlag,
   output logic            programErrorFlag,
   output logic            eraseErrorFlag,
   output logic            deepPowerDown,
   output logic [7:0]      volReadParams,
   output logic            swResetPulse,
   output logic            hwResetActive,
   output logic            abortOperation
);

   // ---------------------------------------------------------------
   // core domain state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] togSync;
      logic       togSeen;
      logic [1:0] holdSync;
      logic [1:0] dedSync;
      logic       armed;
      logic       protErr;
      logic       progErr;
      logic       eraseErr;
      logic       deepPd;
      logic [7:0] volRp;
      logic [3:0] rstCnt;
      logic       hwRst;
      logic       linkRun;
      logic       swRst;
      logic       abort;
   } fir_core_t;

   fir_core_t core_reg;
   fir_core_t core_next;

   localparam logic [3:0] TRST_CYC = 4'(`FIR_TRST_CYC);

   // link side signals read by the core
   logic       cmdTog;
   logic [7:0] cmdCode;

   logic cmdNew;
   logic pinLow;
   logic anyReset;

   always_comb begin
      cmdNew = core_reg.togSync[1] ^ core_reg.togSeen;
      // shared pin only in single-line mode with quad disabled
      pinLow = (!core_reg.holdSync[1] && core_reg.volRp[`FIR_RP_HOLDRST_BIT]
                && !quadCommandMode && !quadEnableBit)
               || (!core_reg.dedSync[1] && !dedResetDisable);
      anyReset = 1'b0;
      core_next = core_reg;
      core_next.togSync = {core_reg.togSync[0], cmdTog};
      core_next.togSeen = core_reg.togSync[1];
      core_next.holdSync = {core_reg.holdSync[0], holdResetN};
      core_next.dedSync = {core_reg.dedSync[0], dedResetN};
      core_next.swRst = 1'b0;
      core_next.abort = 1'b0;
      if (deepPdEnter) begin
         core_next.deepPd = 1'b1;
      end
      if (cmdNew && !core_reg.hwRst) begin
         if (core_reg.deepPd) begin
            // power-down listens to the release opcode alone
            if (cmdCode == `FIR_OP_LEGACY_ID && !writeInProgressFlag) begin
               core_next.deepPd = 1'b0;
            end
         end else begin
            core_next.armed = (cmdCode == `FIR_OP_RESET_ARM);
            if (cmdCode == `FIR_OP_RESET && core_reg.armed) begin
               core_next.swRst = 1'b1;
               anyReset = 1'b1;
            end
            if (cmdCode == `FIR_OP_CLEAR_ERR) begin
               core_next.protErr = 1'b0;
               core_next.progErr = 1'b0;
               core_next.eraseErr = 1'b0;
            end
         end
      end
      // pin must stay low for the full minimum width before it counts
      if (pinLow) begin
         if (core_reg.rstCnt != TRST_CYC) begin
            core_next.rstCnt = core_reg.rstCnt + 4'h1;
         end else if (!core_reg.hwRst) begin
            core_next.hwRst = 1'b1;
            anyReset = 1'b1;
         end
      end else begin
         core_next.rstCnt = 4'h0;
         core_next.hwRst = 1'b0;
      end
      if (anyReset) begin
         core_next.volRp = nvReadParams;
         core_next.deepPd = 1'b0;
         core_next.armed = 1'b0;
         core_next.abort = writeInProgressFlag;
      end
      // error events win over a clear in the same cycle
      if (protErrSet) begin
         core_next.protErr = 1'b1;
      end
      if (progErrSet) begin
         core_next.progErr = 1'b1;
      end
      if (eraseErrSet) begin
         core_next.eraseErr = 1'b1;
      end
      core_next.linkRun = !core_next.hwRst;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         core_reg <= '{togSync: 2'b00, togSeen: 1'b0, holdSync: 2'b11, dedSync: 2'b11,
                       armed: 1'b0, protErr: 1'b0, progErr: 1'b0, eraseErr: 1'b0,
                       deepPd: 1'b0, volRp: `FIR_RP_RST, rstCnt: 4'h0, hwRst: 1'b0,
                       linkRun: 1'b0, swRst: 1'b0, abort: 1'b0};
      end else begin
         core_reg <= core_next;
      end
   end

   assign protectionErrorFlag = core_reg.protErr;
   assign programErrorFlag = core_reg.progErr;
   assign eraseErrorFlag = core_reg.eraseErr;
   assign deepPowerDown = core_reg.deepPd;
   assign volReadParams = core_reg.volRp;
   assign swResetPulse = core_reg.swRst;
   assign hwResetActive = core_reg.hwRst;
   assign abortOperation = core_reg.abort;

   // ---------------------------------------------------------------
   // link domain
   // ---------------------------------------------------------------
   typedef struct packed {
      fir_phase_t phase;
      fir_kind_t  kind;
      logic [5:0] bitCnt;
      logic [5:0] skipTotal;
      logic [7:0] opc;
      logic [23:0] addr;
      logic       sel;
      logic       addrBad;
      logic [3:0] outIdx;
      logic [2:0] bitPos;
   } fir_link_t;

   fir_link_t link_reg;
   fir_link_t link_next;

   logic [1:0] quadSync;
   logic [1:0] pdSync;
   logic [3:0] dummySync0;
   logic [3:0] dummySync1;
   logic       opDone;
   logic [7:0] opFull;
   logic [23:0] addrNow;
   logic [5:0] dummyClocks;
   logic [7:0] curByte;
   logic       outBit;
   logic       outOeN;

   function automatic fir_kind_t decodeKind(input logic [7:0] op, input logic quad, input logic pd);
      fir_kind_t k;
      k = KD_NONE;
      if (!pd) begin
         if (op == `FIR_OP_LEGACY_ID) begin
            k = KD_LEG;
         end else if ((op == `FIR_OP_STD_ID && !quad) || (op == `FIR_OP_STD_ID_QUAD && quad)) begin
            k = KD_STD;
         end else if (op == `FIR_OP_MAKER_PART) begin
            k = KD_MD;
         end else if (op == `FIR_OP_UNIQUE) begin
            k = KD_UID;
         end else if (op == `FIR_OP_PARAM_TBL && !quad) begin
            k = KD_SFDP;
         end
      end
      return k;
   endfunction : decodeKind

   function automatic logic [3:0] nextIdx(input fir_kind_t k, input logic [3:0] idx);
      logic [3:0] n;
      n = idx + 4'h1;
      if (k == KD_LEG) begin
         n = 4'h0;
      end else if (k == KD_STD && idx == 4'h2) begin
         n = 4'h0;
      end else if (k == KD_MD) begin
         n = {3'b000, ~idx[0]};
      end
      return n;
   endfunction : nextIdx

   always_comb begin
      dummyClocks = (dummySync1 == 4'h0) ? `FIR_DUMMY_DEFAULT : {2'b00, dummySync1};
      opFull = {link_reg.opc[6:0], si};
      opDone = (link_reg.phase == PH_OPC) && (link_reg.bitCnt == 6'h07);
      addrNow = (link_reg.bitCnt < `FIR_ADDR_BITS) ? {link_reg.addr[22:0], si} : link_reg.addr;
      case (link_reg.kind)
         KD_LEG:  curByte = DEVICE_ID;
         KD_STD:  curByte = (link_reg.outIdx == 4'h0) ? MAKER_ID :
                            (link_reg.outIdx == 4'h1) ? TYPE_CAP[15:8] : TYPE_CAP[7:0];
         KD_MD:   curByte = (link_reg.outIdx[0] ^ link_reg.sel) ? DEVICE_ID : MAKER_ID;
         KD_UID:  curByte = link_reg.addrBad ? 8'hff : UNIQUE_NO[8'(8'd127 - {link_reg.outIdx, 3'b000}) -: 8];
         KD_SFDP: curByte = PARAM_TBL[8'(8'd127 - {link_reg.outIdx, 3'b000}) -: 8];
         default: curByte = 8'h00;
      endcase
      link_next = link_reg;
      case (link_reg.phase)
         PH_OPC: begin
            link_next.opc = opFull;
            link_next.bitCnt = link_reg.bitCnt + 6'h01;
            if (opDone) begin
               link_next.bitCnt = 6'h00;
               link_next.kind = decodeKind(opFull, quadSync[1], pdSync[1]);
               case (decodeKind(opFull, quadSync[1], pdSync[1]))
                  KD_LEG:  link_next.skipTotal = `FIR_LEGACY_SKIP;
                  KD_MD:   link_next.skipTotal = `FIR_MAKER_SKIP;
                  KD_UID:  link_next.skipTotal = 6'(`FIR_ADDR_BITS + dummyClocks);
                  KD_SFDP: link_next.skipTotal = 6'(`FIR_ADDR_BITS + `FIR_DUMMY_DEFAULT);
                  default: link_next.skipTotal = 6'h00;
               endcase
               if (decodeKind(opFull, quadSync[1], pdSync[1]) == KD_NONE) begin
                  link_next.phase = PH_IDLE;
               end else if (decodeKind(opFull, quadSync[1], pdSync[1]) == KD_STD) begin
                  link_next.phase = PH_OUT;
               end else begin
                  link_next.phase = PH_SKIP;
               end
            end
         end
         PH_SKIP: begin
            // address and dummy bits sampled on rising edges
            link_next.addr = addrNow;
            link_next.bitCnt = link_reg.bitCnt + 6'h01;
            if (link_reg.bitCnt == link_reg.skipTotal - 6'h01) begin
               link_next.phase = PH_OUT;
               link_next.sel = addrNow[0];
               link_next.addrBad = (addrNow[8:4] != 5'h00);
               link_next.outIdx = (link_reg.kind == KD_UID || link_reg.kind == KD_SFDP) ?
                                  addrNow[3:0] : 4'h0;
            end
         end
         PH_OUT: begin
            link_next.bitPos = link_reg.bitPos - 3'h1;
            if (link_reg.bitPos == 3'h0) begin
               link_next.outIdx = nextIdx(link_reg.kind, link_reg.outIdx);
            end
         end
         default: link_next.phase = PH_IDLE;
      endcase
   end

   // frame state dies with select high or with hardware reset
   always_ff @(posedge sclk or posedge csN or negedge core_reg.linkRun) begin
      if (csN || !core_reg.linkRun) begin
         link_reg <= '{phase: PH_OPC, kind: KD_NONE, bitCnt: 6'h00, skipTotal: 6'h00,
                       opc: 8'h00, addr: 24'h000000, sel: 1'b0, addrBad: 1'b0,
                       outIdx: 4'h0, bitPos: 3'h7};
      end else begin
         link_reg <= link_next;
      end
   end

   // survives frame end so the core can fetch the opcode after select rises
   always_ff @(posedge sclk or negedge core_reg.linkRun) begin
      if (!core_reg.linkRun) begin
         cmdTog <= 1'b0;
         cmdCode <= 8'h00;
         quadSync <= 2'b00;
         pdSync <= 2'b00;
         dummySync0 <= 4'h0;
         dummySync1 <= 4'h0;
      end else begin
         quadSync <= {quadSync[0], quadCommandMode};
         pdSync <= {pdSync[0], core_reg.deepPd};
         dummySync0 <= core_reg.volRp[`FIR_RP_DUMMY_LSB +: 4];
         dummySync1 <= dummySync0;
         if (opDone && !csN) begin
            cmdTog <= ~cmdTog;
            cmdCode <= opFull;
         end
      end
   end

   // output changes on falling edges, floats outside the data phase
   always_ff @(negedge sclk or posedge csN or negedge core_reg.linkRun) begin
      if (csN || !core_reg.linkRun) begin
         outBit <= 1'b0;
         outOeN <= 1'b1;
      end else begin
         outBit <= curByte[link_reg.bitPos];
         outOeN <= (link_reg.phase != PH_OUT);
      end
   end

   assign so = outBit;
   assign soOeN = outOeN;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   logic [3:0] lowCnt;
   always_ff @(posedge core_clk) begin
      if (!rst_b || !pinLow) begin
         lowCnt <= 4'h0;
      end else if (lowCnt != 4'hf) begin
         lowCnt <= lowCnt + 4'h1;
      end
   end

   AST_CLEAR_ERR: assert property (cmdNew && !core_reg.hwRst && !core_reg.deepPd && cmdCode == `FIR_OP_CLEAR_ERR
      && !protErrSet && !progErrSet && !eraseErrSet |=> !protectionErrorFlag && !programErrorFlag
      && !eraseErrorFlag) else $error("clear command left an error flag set");
   AST_ERR_STICKY: assert property (protectionErrorFlag && !(cmdNew && cmdCode == `FIR_OP_CLEAR_ERR)
      |=> protectionErrorFlag) else $error("error flag dropped without clear");
   AST_SET_WINS: assert property (eraseErrSet |=> eraseErrorFlag)
      else $error("error event lost");
   AST_NOP_DISARM: assert property (cmdNew && !core_reg.deepPd && !core_reg.hwRst && cmdCode == `FIR_OP_NOP
      |=> !core_reg.armed) else $error("nop left reset armed");
   AST_ARM_THEN_RESET: assert property ($rose(swResetPulse) |-> $past(core_reg.armed, 1)
      && $past(cmdCode == `FIR_OP_RESET, 1)) else $error("software reset without arm");
   AST_SW_RELOAD: assert property (swResetPulse |-> volReadParams == $past(nvReadParams, 1))
      else $error("read params not reloaded");
   AST_HW_MIN_WIDTH: assert property ($rose(hwResetActive) |-> $past(lowCnt, 1) >= TRST_CYC)
      else $error("hardware reset taken too early");
   AST_HW_PD_EXIT: assert property ($rose(hwResetActive) && !$past(deepPdEnter, 1) |-> !deepPowerDown)
      else $error("hardware reset kept power-down");
   AST_ABORT: assert property ((swResetPulse || $rose(hwResetActive)) && $past(writeInProgressFlag, 1)
      |-> abortOperation) else $error("reset did not abort write");
   AST_PD_RELEASE: assert property (cmdNew && !core_reg.hwRst && core_reg.deepPd && !deepPdEnter
      && cmdCode == `FIR_OP_LEGACY_ID |=> deepPowerDown == writeInProgressFlag ##0 1'b1)
      else $error("power-down release wrong");

   CVR_SW_RESET: cover property (swResetPulse);
   CVR_HW_RESET: cover property ($rose(hwResetActive));
   CVR_CLEAR: cover property (protectionErrorFlag ##[1:100] !protectionErrorFlag);
   CVR_PD_EXIT: cover property (deepPowerDown ##1 !deepPowerDown);

endmodule : fir_ident_reset

// ### core/fir_pkg.sv
package fir_pkg;
   typedef enum logic [1:0] {
      PH_OPC  = 2'b00,
      PH_SKIP = 2'b01,
      PH_OUT  = 2'b10,
      PH_IDLE = 2'b11
   } fir_phase_t;

   typedef enum logic [2:0] {
      KD_NONE = 3'b000,
      KD_LEG  = 3'b001,
      KD_STD  = 3'b010,
      KD_MD   = 3'b011,
      KD_UID  = 3'b100,
      KD_SFDP = 3'b101
   } fir_kind_t;
endpackage : fir_pkg

// ### core/fir_regs.svh
`ifndef FIR_REGS_SVH
`define FIR_REGS_SVH
// Behaviour
// - opcode 82h clears the protection, program and erase error flags.
// - an error flag once set stays set until the clear command runs.
// - legacy id read ABh: three dummy bytes follow, sampled on rising edges.
// - then the 8-bit device id goes out msb first on falling edges.
// - further clocks with select low repeat the same device id byte.
// - 9Fh in single-line, AFh in quad mode: maker byte then two-byte code.
// - select still low after the code restarts maker plus code, looping.
// - maker/part read 90h: two dummy bytes then one address byte, rising edges.
// - address bit 0 low sends maker byte first, high sends device byte first.
// - maker and device bytes alternate while select stays low.
// - unique read 4Bh: three address bytes, configured dummies, then 16 bytes.
// - unique number bytes repeat cyclically while select low and clock runs.
// - unique read starts at address bits 3..0; bits 8..4 must be zero.
// - parameter table read 5Ah: three address bytes, 8 dummies, data until select rises.
// - parameter table read is refused in quad command mode.
// - opcode 00h only cancels a pending reset arm.
// - reset needs 66h in one frame then 99h next; anything between disarms.
// - software reset reloads volatile registers from non-volatile, freeze and lock kept.
// - shared pin resets only in single-line mode with quad enable 0; dedicated pin unless disabled.
// - reset pin low 100ns aborts work, leaves power-down, floats output, resets read params.
// - any reset during program or erase aborts that operation.
// - ABh leaves deep power-down, ignored while a write cycle runs.

`define FIR_OP_CLEAR_ERR   8'h82
`define FIR_OP_LEGACY_ID   8'hab
`define FIR_OP_STD_ID      8'h9f
`define FIR_OP_STD_ID_QUAD 8'haf
`define FIR_OP_MAKER_PART  8'h90
`define FIR_OP_UNIQUE      8'h4b
`define FIR_OP_PARAM_TBL   8'h5a
`define FIR_OP_NOP         8'h00
`define FIR_OP_RESET_ARM   8'h66
`define FIR_OP_RESET       8'h99

`define FIR_RP_DUMMY_LSB   3
`define FIR_RP_HOLDRST_BIT 7
`define FIR_RP_RST         8'h00
`define FIR_DUMMY_DEFAULT  6'h08
`define FIR_ADDR_BITS      6'h18
`define FIR_LEGACY_SKIP    6'h18
`define FIR_MAKER_SKIP     6'h18

`define FIR_CORE_PERIOD_NS 10
`define FIR_TRST_NS        100
`define FIR_TRST_CYC       ((`FIR_TRST_NS + `FIR_CORE_PERIOD_NS - 1) / `FIR_CORE_PERIOD_NS)
`endif

// ### testbench/fir_host_model.sv
module fir_host_model (
   input  wire logic       linkClk,
   input  wire logic       so,
   input  wire logic       soOeN,
   output logic            sclk,
   output logic            csN,
   output logic            si,
   output logic [7:0]      rxByte,
   output logic            rxValid
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      sclk = 1'b0;
      csN = 1'b1;
      si = 1'b0;
      rxByte = 8'h00;
      rxValid = 1'b0;
   end

   // ------------------------------------
   // one frame; clock idles low outside
   // ------------------------------------
   task automatic xfer(input logic [31:0] tx, input int nTx, input int nDum, input int nRx);
      @(posedge linkClk);
      csN <= 1'b0;
      si <= tx[nTx-1];
      for (int i = 1; i <= nTx + nDum; i++) begin
         @(posedge linkClk);
         sclk <= 1'b1;
         @(posedge linkClk);
         sclk <= 1'b0;
         si <= (i < nTx) ? tx[nTx-1-i] : ~si;
      end
      for (int b = 0; b < nRx; b++) begin
         for (int k = 7; k >= 0; k--) begin
            @(posedge linkClk);
            // a released output reads as unknown
            rxByte[k] <= (soOeN === 1'b0) ? so : 1'bx;
            sclk <= 1'b1;
            si <= ~si;
            @(posedge linkClk);
            sclk <= 1'b0;
         end
         rxValid <= 1'b1;
         @(posedge linkClk);
         rxValid <= 1'b0;
      end
      @(posedge linkClk);
      csN <= 1'b1;
      si <= ~si;
      repeat (8) @(posedge linkClk);
   endtask : xfer
endmodule : fir_host_model

// ### testbench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [7:0]   MK = 8'h5a;   // arbitrary value
   localparam logic [7:0]   DV = 8'h3c;   // arbitrary value
   localparam logic [15:0]  TC = 16'h1234; // arbitrary value
   localparam logic [127:0] UN = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
   localparam logic [127:0] PT = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;

   logic        coreClk, linkClk, rstB, quadMode, qeBit, holdRstN, dedRstN, dedDis, write_in_progress_flag, pdEnter;
   logic        pSet, gSet, eSet, so, soOeN, sclk, csN, si, rxValid, protF, progF, eraseF;
   logic        pdF, swPulse, hwAct, abortP;
   logic [7:0]  nvRp, volRp, rxByte, e0, e1;
   logic [31:0] r;
   logic [7:0]  expQ[$];
   logic [7:0]  q[$];
   int          num_errors, num_checks, cyc, swCnt, abCnt, s0;

   initial begin
      coreClk = 1'b0;
      forever #5 coreClk = ~coreClk;
   end
   // sclk toggles on every rising edge of this, so 12 ns per sclk period
   initial begin
      linkClk = 1'b0;
      #1.7;
      forever #3 linkClk = ~linkClk;
   end

   fir_ident_reset #(.MAKER_ID(MK), .DEVICE_ID(DV), .TYPE_CAP(TC), .UNIQUE_NO(UN), .PARAM_TBL(PT))
   fir_ident_reset_inst (
      .core_clk(coreClk), .rst_b(rstB), .sclk(sclk), .csN(csN), .si(si), .so(so), .soOeN(soOeN),
      .quadCommandMode(quadMode), .quadEnableBit(qeBit), .holdResetN(holdRstN), .dedResetN(dedRstN),
      .dedResetDisable(dedDis), .writeInProgressFlag(write_in_progress_flag), .deepPdEnter(pdEnter), .protErrSet(pSet),
      .progErrSet(gSet), .eraseErrSet(eSet), .nvReadParams(nvRp), .protectionErrorFlag(protF),
      .programErrorFlag(progF), .eraseErrorFlag(eraseF), .deepPowerDown(pdF), .volReadParams(volRp),
      .swResetPulse(swPulse), .hwResetActive(hwAct), .abortOperation(abortP));
   fir_host_model fir_host_model_inst (.linkClk(linkClk), .so(so), .soOeN(soOeN), .sclk(sclk),
      .csN(csN), .si(si), .rxByte(rxByte), .rxValid(rxValid));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up

   task automatic gap(input int n);
      repeat (n) @(posedge coreClk);
   endtask : gap

   task automatic rd(input logic [31:0] tx, input int nTx, input int nDum, input logic [7:0] e[$]);
      foreach (e[i]) expQ.push_back(e[i]);
      fir_host_model_inst.xfer(tx, nTx, nDum, e.size());
      gap(8);
   endtask : rd

   task automatic cmd(input logic [7:0] op);
      fir_host_model_inst.xfer({24'h0, op}, 8, 0, 0);
      gap(8);
   endtask : cmd

   always @(posedge linkClk) begin
      if (rxValid === 1'b1) begin
         check(rxByte, expQ.pop_front());
      end
   end

   // all runs end well before this ceiling
   always @(posedge coreClk) begin
      cyc <= cyc + 1;
      swCnt <= swCnt + int'(swPulse === 1'b1);
      abCnt <= abCnt + int'(abortP === 1'b1);
      if (cyc == 30000) begin
         num_errors++;
         wrap_up();
      end
   end

   initial begin
      {rstB, quadMode, qeBit, write_in_progress_flag, pdEnter, pSet, gSet, eSet, dedDis} = '0;
      {holdRstN, dedRstN} = 2'b11;
      nvRp = 8'h00;
      void'($urandom(32'h6b4c0041));
      repeat (10) @(posedge coreClk);
      rstB <= 1'b1;
      gap(4);
      r = $urandom();
      rd({8'hab, r[23:0]}, 32, 0, '{DV, DV, DV});
      rd(32'h9f, 8, 0, '{MK, TC[15:8], TC[7:0], MK, TC[15:8]});
      rd(32'haf, 8, 0, '{8'hxx});
      quadMode <= 1'b1;
      rd(32'haf, 8, 0, '{MK, TC[15:8], TC[7:0]});
      rd(32'h9f, 8, 0, '{8'hxx});
      rd({8'h5a, 24'h00000f}, 32, 8, '{8'hxx});
      quadMode <= 1'b0;
      rd({8'h5a, 24'h00000f}, 32, 8, '{PT[7:0], PT[127:120]});
      $display("test identification reads done");
      for (int a = 0; a < 2; a++) begin
         e0 = a[0] ? DV : MK;
         e1 = a[0] ? MK : DV;
         rd({8'h90, r[23:1], a[0]}, 32, 0, '{e0, e1, e0, e1});
      end
      for (int k = 0; k < 17; k++) q.push_back(UN[127 - 8 * ((r[3:0] + k) % 16) -: 8]);
      rd({8'h4b, r[23:9], 5'h00, r[3:0]}, 32, 8, q);
      rd({8'h4b, 24'h000010}, 32, 8, '{8'hff});
      $display("test maker part and unique reads done");
      {pSet, gSet, eSet} <= 3'b111;
      gap(1);
      {pSet, gSet, eSet} <= 3'b000;
      gap(2);
      check({5'h00, protF, progF, eraseF}, 8'h07);
      cmd(8'h00);
      check({5'h00, protF, progF, eraseF}, 8'h07);
      cmd(8'h82);
      check({5'h00, protF, progF, eraseF}, 8'h00);
      $display("test error flags done");
      nvRp <= {1'b1, r[30:24]};
      s0 = swCnt;
      cmd(8'h66);
      cmd(8'h00);
      cmd(8'h99);
      check(8'(swCnt - s0), 8'h00);
      check(volRp, 8'h00);
      cmd(8'h66);
      write_in_progress_flag <= 1'b1;
      cmd(8'h99);
      check(8'(swCnt - s0), 8'h01);
      check(8'(abCnt), 8'h01);
      check(volRp, nvRp);
      write_in_progress_flag <= 1'b0;
      pdEnter <= 1'b1;
      gap(1);
      pdEnter <= 1'b0;
      gap(2);
      check({7'h00, pdF}, 8'h01);
      rd(32'h9f, 8, 0, '{8'hxx});
      write_in_progress_flag <= 1'b1;
      cmd(8'hab);
      check({7'h00, pdF}, 8'h01);
      write_in_progress_flag <= 1'b0;
      cmd(8'hab);
      check({7'h00, pdF}, 8'h00);
      $display("test software reset and power down done");
      for (int c = 0; c < 5; c++) begin
         dedDis <= (c == 1);
         qeBit <= (c == 3);
         quadMode <= (c == 4);
         dedRstN <= (c > 1);
         holdRstN <= (c < 2);
         write_in_progress_flag <= (c == 0);
         gap(16);
         check({6'h00, hwAct, soOeN}, {6'h00, c == 0 || c == 2, 1'b1});
         {holdRstN, dedRstN, write_in_progress_flag} <= 3'b110;
         gap(8);
      end
      check(8'(abCnt), 8'h02);
      quadMode <= 1'b0;
      gap(3500);
      rd(32'h9f, 8, 0, '{MK, TC[15:8]});
      $display("test hardware reset done");
      wrap_up();
   end
endmodule : testbench
